// >>> hw/ovl_pkg.sv
package ovl_pkg;

   // Bus widths
   localparam int unsigned OVL_AW = 32;
   localparam int unsigned OVL_DW = 32;

   // Register byte addresses
   localparam logic [31:0] OVL_STATUS_ADDR = 32'hf0030358;
   localparam logic [31:0] OVL_VCTRL_ADDR = 32'hf0030384;
   localparam logic [31:0] OVL_PHASE_ADDR = 32'hf0030430;
   localparam logic [31:0] OVL_PEND_ADDR = 32'hf0030440;
   localparam logic [31:0] OVL_MASK_ADDR = 32'hf0030444;

   // Values after reset
   localparam logic [31:0] OVL_VCTRL_RST = 32'h0000_0000;
   localparam logic [31:0] OVL_PHASE_RST = 32'h0000_0000;
   localparam logic [31:0] OVL_MASK_RST = 32'h0000_0000;
   localparam logic [14:0] OVL_FLAG_RST = 15'h0000;

   // Writable bits of each read-write register
   localparam logic [31:0] OVL_VCTRL_WMASK = 32'h0000_003d;
   localparam logic [31:0] OVL_PHASE_WMASK = 32'h0007_0007;
   localparam logic [31:0] OVL_MASK_WMASK = 32'h007c_7c7c;

   // Event flag layout: channel c, event e sits at 2 + 8*c + e
   localparam int unsigned OVL_NUM_CH = 3;
   localparam int unsigned OVL_NUM_EVT = 5;
   localparam int unsigned OVL_NFLAG = 15;
   localparam int unsigned OVL_EVT_LSB = 2;
   localparam int unsigned OVL_CH_STRIDE = 8;
   localparam int unsigned OVL_V_CH = 2;

   // Event positions inside one channel group
   localparam int unsigned OVL_EV_XEND = 0;
   localparam int unsigned OVL_EV_BASE_DESCRIPTOR_LOADED_FLAG = 1;
   localparam int unsigned OVL_EV_HEAD = 2;
   localparam int unsigned OVL_EV_LEND = 3;
   localparam int unsigned OVL_EV_OVR = 4;

   // V control register fields
   localparam int unsigned OVL_VC_FETCH = 0;
   localparam int unsigned OVL_VC_XEND_IE = 2;
   localparam int unsigned OVL_VC_BASE_DESCRIPTOR_LOADED_FLAG_IE = 3;
   localparam int unsigned OVL_VC_HEAD_IE = 4;
   localparam int unsigned OVL_VC_LEND_IE = 5;

   // Phase offset fields
   localparam int unsigned OVL_PH_W = 3;
   localparam int unsigned OVL_XPH_LSB = 0;
   localparam int unsigned OVL_YPH_LSB = 16;
   localparam logic [2:0] OVL_PH_RST = 3'h0;

   // AXI response codes
   localparam logic [1:0] OVL_RESP_OKAY = 2'h0;
   localparam logic [1:0] OVL_RESP_DECERR = 2'h3;

   // One channel's events, bit 0 is end of transfer
   typedef struct packed {
      logic overflow;
      logic list_end;
      logic head_loaded;
      logic base_descriptor_loaded_flag_loaded;
      logic xfer_end;
   } ovl_evt_s;

   // Channel 0 base, 1 U, 2 V
   typedef ovl_evt_s [OVL_NUM_CH-1:0] ovl_evt_vec_t;

   // Scaler start request and step for one direction
   typedef struct packed {
      logic start;
      logic step;
   } ovl_scale_s;

   typedef enum logic [1:0] {WR_IDLE, WR_TAKE, WR_RESP} ovl_wr_state_e;
   typedef enum logic [1:0] {RD_IDLE, RD_TAKE, RD_RESP} ovl_rd_state_e;

endpackage

// >>> hw/ovl_event_flag.sv
`timescale 1ns/1ps
`default_nettype none

module ovl_event_flag
   import ovl_pkg::*;
#(
   parameter int unsigned W = 15
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Set and clear strobes
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // Sticky flags
   output logic [W-1:0] flags_q
);

   logic [W-1:0] flags_d;

   // Set wins over clear so a coincident event is never lost
   always_comb
   begin
      flags_d = (flags_q & ~clr) | set;
   end

   // Flag storage
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags_q <= '0;
      else
         flags_q <= flags_d;
   end

endmodule

`default_nettype wire

// >>> hw/ovl_dma_status.sv
// Summary of operation
// - Status flags sticky, set by hardware, cleared by read, writes ignored
// - End-of-transfer flag sets at bits 2, 10, 18 per channel
// - Descriptor-loaded flag sets at bits 3, 11, 19 per channel
// - Head-descriptor-loaded flag sets at bits 4, 12, 20 per channel
// - End-of-list flag sets at bits 5, 13, 21 per channel
// - Overflow flag sets at bits 6, 14, 22 per channel
// - V channel fetches descriptors only while control bit 0 is one; here the registered grant follows the bit one cycle late, both on and off
// - V end-of-transfer interrupt enable, bit 2, zero enables
// - V descriptor-loaded interrupt enable, bit 3, zero enables
// - V head-added interrupt enable, bit 4, one enables
// - V end-of-list interrupt enable, bit 5, one enables
// - Horizontal scaler starts at the programmed horizontal phase offset
// - Vertical scaler starts at the programmed vertical phase offset
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ovl_dma_status
   import ovl_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [OVL_AW-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [OVL_DW-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [OVL_AW-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [OVL_DW-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel events, one-cycle pulses
   input wire ovl_evt_vec_t chan_evt,
   // V channel descriptor fetch
   input wire logic v_fetch_req,
   output logic v_fetch_grant,
   output logic v_descriptor_fetch_enable,
   // Resampling control
   input wire ovl_scale_s h_scale,
   input wire ovl_scale_s v_scale,
   output logic [OVL_PH_W-1:0] h_coef_idx,
   output logic [OVL_PH_W-1:0] v_coef_idx,
   // Layer interrupt
   output logic irq
);

   // Spread the flat 15 flags onto their register bit positions
   function automatic logic [31:0] spread(input logic [14:0] f);
      logic [31:0] r;
      r = '0;
      for (int c = 0; c < OVL_NUM_CH; c++)
      begin
         for (int e = 0; e < OVL_NUM_EVT; e++)
         begin
            r[OVL_EVT_LSB + OVL_CH_STRIDE*c + e] = f[OVL_NUM_EVT*c + e];
         end
      end
      return r;
   endfunction

   // Gather register bit positions back into the flat flag order
   function automatic logic [14:0] gather(input logic [31:0] r);
      logic [14:0] f;
      f = '0;
      for (int c = 0; c < OVL_NUM_CH; c++)
      begin
         for (int e = 0; e < OVL_NUM_EVT; e++)
         begin
            f[OVL_NUM_EVT*c + e] = r[OVL_EVT_LSB + OVL_CH_STRIDE*c + e];
         end
      end
      return f;
   endfunction

   // Byte enables widened to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++)
      begin
         m[8*b +: 8] = {8{s[b]}};
      end
      return m;
   endfunction

   ovl_wr_state_e wr_state_q, wr_state_d;
   ovl_rd_state_e rd_state_q, rd_state_d;
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] vctrl_q, vctrl_d;
   logic [31:0] phase_q, phase_d;
   logic [31:0] mask_q, mask_d;
   logic [14:0] evt_flat;
   logic [14:0] rc_flags;
   logic [14:0] pend_flags;
   logic [14:0] rc_clr;
   logic [14:0] pend_clr;
   logic [14:0] eff_en;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] wmask;
   logic irq_q, irq_d;
   logic grant_q, grant_d;
   logic [OVL_PH_W-1:0] h_idx_q, h_idx_d;
   logic [OVL_PH_W-1:0] v_idx_q, v_idx_d;

   // Events as one flat vector, channel 0 in the low bits
   assign evt_flat = chan_evt;

   // Write and read accept strobes, valid held by the master meanwhile
   assign wr_fire = (wr_state_q == WR_TAKE);
   assign rd_fire = (rd_state_q == RD_TAKE);
   assign wmask = strb_mask(s_axi_wstrb);

   // Read-to-clear status, cleared only by a status read
   always_comb
   begin
      rc_clr = '0;
      if (rd_fire && s_axi_araddr == OVL_STATUS_ADDR)
         rc_clr = '1;
   end

   // Companion pending register, cleared by writing ones
   always_comb
   begin
      pend_clr = '0;
      if (wr_fire && s_axi_awaddr == OVL_PEND_ADDR)
         pend_clr = gather(s_axi_wdata & wmask);
   end

   // Status flags, a set in the clearing cycle survives
   ovl_event_flag #(
      .W(OVL_NFLAG)
   ) u_status_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(evt_flat),
      .clr(rc_clr),
      .flags_q(rc_flags)
   );

   // Interrupt pending flags
   ovl_event_flag #(
      .W(OVL_NFLAG)
   ) u_pend_flags (
      .aclk(aclk),
      .aresetn(aresetn),
      .set(evt_flat),
      .clr(pend_clr),
      .flags_q(pend_flags)
   );

   // Write channel: both halves taken together, response follows
   always_comb
   begin
      wr_state_d = wr_state_q;
      awready_d = 1'b0;
      wready_d = 1'b0;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      case (wr_state_q)
         WR_IDLE:
         begin
            if (s_axi_awvalid && s_axi_wvalid)
            begin
               awready_d = 1'b1;
               wready_d = 1'b1;
               wr_state_d = WR_TAKE;
            end
         end
         WR_TAKE:
         begin
            bvalid_d = 1'b1;
            case (s_axi_awaddr)
               OVL_STATUS_ADDR, OVL_VCTRL_ADDR, OVL_PHASE_ADDR,
               OVL_PEND_ADDR, OVL_MASK_ADDR: bresp_d = OVL_RESP_OKAY;
               default: bresp_d = OVL_RESP_DECERR;
            endcase
            wr_state_d = WR_RESP;
         end
         WR_RESP:
         begin
            if (s_axi_bready)
            begin
               bvalid_d = 1'b0;
               wr_state_d = WR_IDLE;
            end
         end
         default:
         begin
            bvalid_d = 1'b0;
            wr_state_d = WR_IDLE;
         end
      endcase
   end

   // Register writes; a write to the status word changes nothing
   always_comb
   begin
      vctrl_d = vctrl_q;
      phase_d = phase_q;
      mask_d = mask_q;
      if (wr_fire)
      begin
         case (s_axi_awaddr)
            OVL_VCTRL_ADDR:
               vctrl_d = (vctrl_q & ~(wmask & OVL_VCTRL_WMASK)) |
                  (s_axi_wdata & wmask & OVL_VCTRL_WMASK);
            OVL_PHASE_ADDR:
               phase_d = (phase_q & ~(wmask & OVL_PHASE_WMASK)) |
                  (s_axi_wdata & wmask & OVL_PHASE_WMASK);
            OVL_MASK_ADDR:
               mask_d = (mask_q & ~(wmask & OVL_MASK_WMASK)) |
                  (s_axi_wdata & wmask & OVL_MASK_WMASK);
            default:
               mask_d = mask_q;
         endcase
      end
   end

   // Read channel: data captured in the accept cycle
   always_comb
   begin
      rd_state_d = rd_state_q;
      arready_d = 1'b0;
      rvalid_d = rvalid_q;
      rresp_d = rresp_q;
      rdata_d = rdata_q;
      case (rd_state_q)
         RD_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               arready_d = 1'b1;
               rd_state_d = RD_TAKE;
            end
         end
         RD_TAKE:
         begin
            rvalid_d = 1'b1;
            rresp_d = OVL_RESP_OKAY;
            case (s_axi_araddr)
               OVL_STATUS_ADDR: rdata_d = spread(rc_flags);
               OVL_VCTRL_ADDR: rdata_d = vctrl_q;
               OVL_PHASE_ADDR: rdata_d = phase_q;
               OVL_PEND_ADDR: rdata_d = spread(pend_flags);
               OVL_MASK_ADDR: rdata_d = mask_q;
               default:
               begin
                  rdata_d = '0;
                  rresp_d = OVL_RESP_DECERR;
               end
            endcase
            rd_state_d = RD_RESP;
         end
         RD_RESP:
         begin
            if (s_axi_rready)
            begin
               rvalid_d = 1'b0;
               rd_state_d = RD_IDLE;
            end
         end
         default:
         begin
            rvalid_d = 1'b0;
            rd_state_d = RD_IDLE;
         end
      endcase
   end

   // Effective enables; the V group also honours its control enables
   always_comb
   begin
      eff_en = gather(mask_q);
      eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_XEND] =
         eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_XEND] &
         ~vctrl_q[OVL_VC_XEND_IE];
      eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_BASE_DESCRIPTOR_LOADED_FLAG] =
         eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_BASE_DESCRIPTOR_LOADED_FLAG] &
         ~vctrl_q[OVL_VC_BASE_DESCRIPTOR_LOADED_FLAG_IE];
      eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_HEAD] =
         eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_HEAD] &
         vctrl_q[OVL_VC_HEAD_IE];
      eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_LEND] =
         eff_en[OVL_NUM_EVT*OVL_V_CH + OVL_EV_LEND] &
         vctrl_q[OVL_VC_LEND_IE];
   end

   // Level interrupt from pending flags, registered for a clean output
   always_comb
   begin
      irq_d = |(pend_flags & eff_en);
   end

   // Descriptor fetch gating; disabling stops the grant one cycle after the enable bit clears
   always_comb
   begin
      grant_d = v_fetch_req & vctrl_q[OVL_VC_FETCH];
   end

   // Coefficient set index: start loads the phase, step advances modulo 8
   always_comb
   begin
      h_idx_d = h_idx_q;
      v_idx_d = v_idx_q;
      if (h_scale.start)
         h_idx_d = phase_q[OVL_XPH_LSB +: OVL_PH_W];
      else if (h_scale.step)
         h_idx_d = h_idx_q + 3'h1;
      if (v_scale.start)
         v_idx_d = phase_q[OVL_YPH_LSB +: OVL_PH_W];
      else if (v_scale.step)
         v_idx_d = v_idx_q + 3'h1;
   end

   // Bus handshake and response state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_state_q <= WR_IDLE;
         rd_state_q <= RD_IDLE;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= OVL_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= OVL_RESP_OKAY;
         rdata_q <= '0;
      end
      else
      begin
         wr_state_q <= wr_state_d;
         rd_state_q <= rd_state_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rresp_q <= rresp_d;
         rdata_q <= rdata_d;
      end
   end

   // Software-visible configuration and block outputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         vctrl_q <= OVL_VCTRL_RST;
         phase_q <= OVL_PHASE_RST;
         mask_q <= OVL_MASK_RST;
         irq_q <= 1'b0;
         grant_q <= 1'b0;
         h_idx_q <= OVL_PH_RST;
         v_idx_q <= OVL_PH_RST;
      end
      else
      begin
         vctrl_q <= vctrl_d;
         phase_q <= phase_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
         grant_q <= grant_d;
         h_idx_q <= h_idx_d;
         v_idx_q <= v_idx_d;
      end
   end

   // Every output straight from a flip-flop
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign irq = irq_q;
   assign v_fetch_grant = grant_q;
   assign v_descriptor_fetch_enable = vctrl_q[OVL_VC_FETCH];
   assign h_coef_idx = h_idx_q;
   assign v_coef_idx = v_idx_q;

endmodule

`default_nettype wire

// >>> test/ovl_dma_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ovl_dma_status_asserts
   import ovl_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic [OVL_DW-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Events, fetch, scaler and interrupt
   input wire ovl_evt_vec_t chan_evt,
   input wire logic v_fetch_grant,
   input wire logic v_descriptor_fetch_enable,
   input wire ovl_scale_s h_scale,
   input wire logic [OVL_PH_W-1:0] h_coef_idx,
   input wire logic irq
);
   logic any_evt;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Flattened so that a plain signal goes into the sampled functions
   assign any_evt = |chan_evt;
   AST_AW_W_PAIR: assert property (s_axi_awready == s_axi_wready)
      else $error("write ready pair split");
   AST_WR_RESP: assert property (s_axi_awready |=> s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   AST_RD_RESP: assert property (s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready) else $error("read response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
   AST_FETCH_GATE: assert property (
      v_fetch_grant |-> $past(v_descriptor_fetch_enable))
      else $error("fetch while disabled");
   AST_FETCH_EN_SRC: assert property (
      $changed(v_descriptor_fetch_enable) |-> $past(s_axi_wready))
      else $error("fetch enable moved without a write");
   // Interrupt moves only two cycles after an event or a register write
   AST_IRQ_RISE: assert property (
      $rose(irq) |-> $past(any_evt, 2) || $past(s_axi_wready, 2))
      else $error("irq rose without cause");
   AST_IRQ_FALL: assert property (
      $fell(irq) |-> $past(s_axi_wready, 2)) else $error("irq fell early");
   AST_COEF_HOLD: assert property (
      !h_scale.start && !h_scale.step |=> $stable(h_coef_idx))
      else $error("coefficient index drifted");
   // Main scenarios
   cover property (s_axi_rvalid && !s_axi_rready);
   cover property ($rose(irq));
   cover property (v_fetch_grant);
endmodule
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import ovl_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic v_fetch_req = 1'b0, slow = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, grant, fetch_en, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] h_idx, v_idx;
   ovl_evt_vec_t chan_evt = '0;
   ovl_scale_s h_scale = '0, v_scale = '0;
   int num_errors = 0, check_count = 0;
   // 250 MHz clock
   always #2 aclk = ~aclk;
   // Protection bits are ignored and full words are written
   ovl_dma_status dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .chan_evt(chan_evt), .v_fetch_req(v_fetch_req),
      .v_fetch_grant(grant), .v_descriptor_fetch_enable(fetch_en),
      .h_scale(h_scale), .v_scale(v_scale), .h_coef_idx(h_idx),
      .v_coef_idx(v_idx), .irq(irq));
   // Verdict and end of run
   task automatic close_out();
      if (num_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Compare one value
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // Bus write; slow holds bready back until bvalid shows
   task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
      // Let one edge pass so the last release is never overwritten
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !slow;
      do
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid && !bready) bready <= 1'b1;
      end
      while (!(bvalid && bready));
      bready <= 1'b0;
      check(32'(bresp), 32'(er));
   endtask
   // Bus read; ev is pulsed in the cycle where arready stands
   task automatic rd(input logic [31:0] a, ed, input logic [1:0] er,
      input logic [14:0] ev);
      int n;
      n = 0;
      // Let one edge pass so the last release is never overwritten
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= !slow;
      do
      begin
         @(posedge aclk);
         if (n == 0)
            chan_evt <= ev;
         else if (n == 1)
            chan_evt <= 15'h0;
         n++;
         if (arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end
      while (!(rvalid && rready));
      rready <= 1'b0;
      check(rdata, ed);
      check(32'(rresp), 32'(er));
   endtask
   // One-cycle event pulse, then settle two cycles
   task automatic pulse(input int b);
      chan_evt <= 15'h1 << b;
      @(posedge aclk);
      chan_evt <= '0;
      repeat (2) @(posedge aclk);
   endtask
   // Reset values, unmapped place read and write
   task automatic t_reset();
      logic [31:0] adr [5];
      adr = '{OVL_STATUS_ADDR, OVL_VCTRL_ADDR, OVL_PHASE_ADDR,
         OVL_PEND_ADDR, OVL_MASK_ADDR};
      foreach (adr[i]) rd(adr[i], 32'h0, OVL_RESP_OKAY, 15'h0);
      rd(32'hf0030400, 32'h0, OVL_RESP_DECERR, 15'h0);
      wr(32'hf0030400, 32'hffffffff, OVL_RESP_DECERR);
   endtask
   // Every flag lands on its bit and clears on read
   task automatic t_flags();
      int b;
      for (int c = 0; c < 3; c++)
         for (int e = 0; e < 5; e++)
         begin
            pulse(c * 5 + e);
            b = 2 + 8 * c + e;
            rd(OVL_STATUS_ADDR, 32'h1 << b, '0, '0);
            rd(OVL_STATUS_ADDR, 32'h0, 2'h0, 15'h0);
         end
      check(32'(irq), 32'h0);
      pulse(0);
      wr(OVL_STATUS_ADDR, 32'hffffffff, OVL_RESP_OKAY);
      rd(OVL_STATUS_ADDR, 32'h4, 2'h0, 15'h0);
      rd(OVL_STATUS_ADDR, 32'h0, 2'h0, 15'h14 << 10);
      rd(OVL_STATUS_ADDR, 32'h00500000, 2'h0, 15'h0);
   endtask
   // Interrupt through mask and V enables of mixed polarity
   task automatic t_irq();
      wr(OVL_PEND_ADDR, 32'h007c7c7c, 2'h0);
      wr(OVL_MASK_ADDR, 32'h007c7c7c, 2'h0);
      pulse(0);
      check(32'(irq), 32'h1);
      wr(OVL_PEND_ADDR, 32'h4, 2'h0);
      repeat (2) @(posedge aclk);
      check(32'(irq), 32'h0);
      for (int vc = 0; vc < 2; vc++)
      begin
         wr(OVL_VCTRL_ADDR, vc ? 32'h3c : 32'h0, 2'h0);
         for (int e = 0; e < 4; e++)
         begin
            pulse(10 + e);
            check(32'(irq), 32'((e < 2) ^ vc));
            wr(OVL_PEND_ADDR, 32'h1 << (18 + e), 2'h0);
         end
      end
      wr(OVL_MASK_ADDR, 32'h0, 2'h0);
      pulse(5);
      check(32'(irq), 32'h0);
   endtask
   // Descriptor fetch follows the enable bit
   task automatic t_fetch();
      v_fetch_req <= 1'b1;
      // End enabled, so that dropping the request below can be seen
      for (int en = 1; en < 4; en++)
      begin
         wr(OVL_VCTRL_ADDR, 32'(en & 1), 2'h0);
         repeat (2) @(posedge aclk);
         check(32'({fetch_en, grant}), 32'(en & 1) * 32'h3);
      end
      v_fetch_req <= 1'b0;
      repeat (2) @(posedge aclk);
      check(32'(grant), 32'h0);
   endtask
   // Scalers start from the programmed phase; bus answers are stalled
   task automatic t_phase();
      slow = 1'b1;
      wr(OVL_PHASE_ADDR, 32'hffffffff, 2'h0);
      rd(OVL_PHASE_ADDR, 32'h00070007, 2'h0, 15'h0);
      wr(OVL_PHASE_ADDR, 32'h00030005, 2'h0);
      h_scale <= 2'b10;
      v_scale <= 2'b10;
      @(posedge aclk);
      h_scale <= 2'b00;
      v_scale <= 2'b00;
      // Look one edge later, once the loaded index has settled
      @(posedge aclk);
      check(32'(h_idx), 32'h5);
      check(32'(v_idx), 32'h3);
      h_scale <= 2'b01;
      v_scale <= 2'b11;
      @(posedge aclk);
      h_scale <= 2'b00;
      v_scale <= 2'b00;
      @(posedge aclk);
      check(32'(h_idx), 32'h6);
      check(32'(v_idx), 32'h3);
      slow = 1'b0;
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_flags();
      t_irq();
      t_fetch();
      t_phase();
      close_out();
   end
   // Watchdog, far beyond the few hundred cycles needed
   initial
   begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      close_out();
   end
endmodule
bind ovl_dma_status ovl_dma_status_asserts u_asserts (.aclk(aclk),
   .aresetn(aresetn), .s_axi_awready(s_axi_awready),
   .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .chan_evt(chan_evt), .v_fetch_grant(v_fetch_grant),
   .v_descriptor_fetch_enable(v_descriptor_fetch_enable),
   .h_scale(h_scale), .h_coef_idx(h_coef_idx), .irq(irq));
`default_nettype wire
